// *** core/scr_byte_if.sv ***
// Byte handshake between the serial shifter and the register bank.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface scr_byte_if;
  logic       active;    // Select asserted, synchronised
  logic       byte_done; // One-cycle pulse, a byte came in
  logic [7:0] rx_byte;   // Received byte, valid with byte_done
  logic [7:0] tx_byte;   // Byte loaded at the next byte start

  modport port (output active, output byte_done, output rx_byte, input tx_byte);
  modport bank (input active, input byte_done, input rx_byte, output tx_byte);
endinterface // scr_byte_if

// *** core/scr_pkg.sv ***
// Constants and types shared by the configuration and status register bank.
// Assumes a byte-wide serial register port with a 7-bit address and a direction bit.
package scr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [6:0] ADDR_CFG   = 7'h11; // Sensor configuration
  localparam logic [6:0] ADDR_OBS   = 7'h2e; // Mode observation
  localparam logic [6:0] ADDR_KEY   = 7'h3a; // Keyed chip reset, write only
  localparam logic [6:0] ADDR_NREV  = 7'h3e; // Inverted revision
  localparam logic [6:0] ADDR_NPROD = 7'h3f; // Inverted product
  localparam logic [6:0] ADDR_BURST = 7'h42; // Burst readout port

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam int         CFG_CPI_BIT   = 7;     // Resolution select bit
  localparam int         CFG_REST_LSB  = 4;     // Rest force field low bit
  localparam int         OBS_MODE_LSB  = 6;     // Power mode field low bit
  localparam int         HDR_DIR_BIT   = 7;     // Direction bit of header byte
  localparam logic [7:0] RESET_KEY     = 8'h5a; // Key that resets the chip
  localparam logic       CPI_RST       = 1'h0;  // Resolution after reset, 500 cpi
  localparam logic [1:0] REST_RST      = 2'h0;  // Normal operation after reset
  localparam logic [3:0] OBS_TICK_ALL  = 4'hf;  // Tick bits set by a frame
  localparam logic [3:0] OBS_CLEAR     = 4'h0;  // Tick bits after a clear
  localparam logic [7:0] READ_ZERO     = 8'h00; // Reserved data
  localparam logic [2:0] BURST_FIRST   = 3'h1;  // Index after header of a burst
  localparam logic [2:0] BURST_CLR_IDX = 3'h3;  // Bytes sent when motion clears
  localparam logic [2:0] BURST_LAST    = 3'h7;  // Index past the last item
  localparam logic [2:0] BIT_LAST      = 3'h7;  // Last bit of a byte

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_HEADER,  // Next byte is an address header
    PH_WRITE,   // Next byte is write data
    PH_READ     // Bytes go out to the host
  } scr_phase_type;

endpackage

// *** core/scr_regs.sv ***
// Configuration, observation, keyed reset, identity and burst registers.
// Assumes the host is the serial master; sensor data inputs are on REF_CLK.
`timescale 1ns/1ps

// Functional notes
// - Bits 5:4 force rest one to three
// - Bit 7 selects 500 or 1000 cpi
// - Observation bits 7:6 show power mode
// - Every frame sets observation bits 3:0, unless a key write comes in that cycle
// - An observation write clears tick bits unless a frame comes in that cycle
// - Key write to 0x3a resets everything
// - 0x3e reads inverted revision code
// - 0x3f reads inverted product code
// - Burst at 0x42 returns seven fixed bytes
// - Third burst byte clears motion data
module scr_regs #(
  parameter logic [7:0] REVISION_ID = 8'h6a, // Arbitrary value
  parameter logic [7:0] PRODUCT_ID  = 8'h35  // Arbitrary value
) (
  input  wire logic       REF_CLK,      // Reference clock, 250 MHz
  input  wire logic       RST,          // Synchronous reset, active high
  input  wire logic       SCLK,         // Serial clock from host
  input  wire logic       MOSI,         // Serial data from host
  input  wire logic       NCS_N,        // Serial select, active low
  output logic            MISO_O,       // Serial data to host
  output logic            MISO_OE,      // Serial data drive enable
  input  wire logic       FRAME_TICK,   // One pulse per processed frame
  input  wire logic [1:0] POWER_MODE,   // Current power mode
  input  wire logic [7:0] MOTION_STAT,  // Motion status byte
  input  wire logic [7:0] DELTA_Y,      // Y displacement
  input  wire logic [7:0] DELTA_X,      // X displacement
  input  wire logic [7:0] SURF_QUAL,    // Surface quality
  input  wire logic [7:0] SHUTTER_HI,   // Shutter high byte
  input  wire logic [7:0] SHUTTER_LO,   // Shutter low byte
  input  wire logic [7:0] MAX_PIXEL,    // Maximum pixel value
  output logic [1:0]      REST_FORCE,   // Forced rest state request
  output logic            CPI_SELECT,   // High for 1000 cpi
  output logic            CHIP_RESET,   // Pulse, whole chip reset
  output logic            MOTION_CLEAR  // Pulse, clear motion data
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    scr_pkg::scr_phase_type phase;     // Byte role in the frame
    logic [6:0]             addr;      // Address of the transfer
    logic                   burst;     // Burst readout running
    logic [2:0]             burst_idx; // Next burst item
    logic [7:0]             tx;        // Byte offered to the shifter
    logic                   cpi;       // Resolution select
    logic [1:0]             rest;      // Rest force field
    logic [3:0]             frame_tick_bits;       // Frame tick bits
    logic                   chip_rst;  // Reset pulse
    logic                   mclr;      // Motion clear pulse
  } scr_regs_type;

  scr_regs_type q, d;
  scr_byte_if   link ();               // Byte handshake to the shifter
  logic         hdr_done;              // Header byte arrived
  logic         wr_done;               // Write data byte arrived
  logic         rd_done;               // A read byte went out

  // ****************************************************************
  // Serial shifter
  // ****************************************************************
  scr_shifter u_shift (
    .clk      (REF_CLK),
    .rst      (RST),
    .sclk_in  (SCLK),
    .mosi_in  (MOSI),
    .sel_n_in (NCS_N),
    .miso_o   (MISO_O),
    .miso_oe  (MISO_OE),
    .bus      (link.port)
  );

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  // Single register read; unknown or write-only addresses give zero
  function automatic logic [7:0] read_mux(input logic [6:0] a, input scr_regs_type s);
    logic [7:0] v;
    v = scr_pkg::READ_ZERO;
    unique case (a)
      scr_pkg::ADDR_CFG:
      begin
        v[scr_pkg::CFG_CPI_BIT]                      = s.cpi;
        v[scr_pkg::CFG_REST_LSB +: 2]                = s.rest;
      end
      scr_pkg::ADDR_OBS:
      begin
        v[scr_pkg::OBS_MODE_LSB +: 2] = POWER_MODE;
        v[3:0]                        = s.frame_tick_bits;
      end
      scr_pkg::ADDR_NREV:  v = ~REVISION_ID;
      scr_pkg::ADDR_NPROD: v = ~PRODUCT_ID;
      scr_pkg::ADDR_BURST: v = MOTION_STAT;
      default:             v = scr_pkg::READ_ZERO;
    endcase
    return v;
  endfunction

  // Burst items after the motion status byte, zero past the end
  function automatic logic [7:0] burst_mux(input logic [2:0] i);
    logic [7:0] v;
    v = scr_pkg::READ_ZERO;
    unique case (i)
      3'h1:    v = DELTA_Y;
      3'h2:    v = DELTA_X;
      3'h3:    v = SURF_QUAL;
      3'h4:    v = SHUTTER_HI;
      3'h5:    v = SHUTTER_LO;
      3'h6:    v = MAX_PIXEL;
      default: v = scr_pkg::READ_ZERO;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Byte roles, register writes, burst stepping and frame ticks
  always_comb
  begin
    d          = q;
    d.chip_rst = 1'b0;
    d.mclr     = 1'b0;
    hdr_done   = link.byte_done && (q.phase == scr_pkg::PH_HEADER);
    wr_done    = link.byte_done && (q.phase == scr_pkg::PH_WRITE);
    rd_done    = link.byte_done && (q.phase == scr_pkg::PH_READ);
    if (!link.active)
    begin
      // Deselect ends any transfer and any burst
      d.phase = scr_pkg::PH_HEADER;
      d.burst = 1'b0;
    end
    else if (hdr_done)
    begin
      d.addr = link.rx_byte[6:0];
      if (link.rx_byte[scr_pkg::HDR_DIR_BIT])
        d.phase = scr_pkg::PH_WRITE;
      else
      begin
        d.phase     = scr_pkg::PH_READ;
        d.tx        = read_mux(link.rx_byte[6:0], q);
        d.burst     = (link.rx_byte[6:0] == scr_pkg::ADDR_BURST);
        d.burst_idx = scr_pkg::BURST_FIRST;
      end
    end
    else if (wr_done)
    begin
      // A further header may follow in the same frame
      d.phase = scr_pkg::PH_HEADER;
      unique case (q.addr)
        scr_pkg::ADDR_CFG:
        begin
          d.cpi  = link.rx_byte[scr_pkg::CFG_CPI_BIT];
          d.rest = link.rx_byte[scr_pkg::CFG_REST_LSB +: 2];
        end
        scr_pkg::ADDR_OBS: d.frame_tick_bits = scr_pkg::OBS_CLEAR;
        default:           d.frame_tick_bits = q.frame_tick_bits;
      endcase
    end
    else if (rd_done)
    begin
      // Single reads repeat zero; bursts step through the items
      d.tx = scr_pkg::READ_ZERO;
      if (q.burst && (q.burst_idx != scr_pkg::BURST_LAST))
      begin
        d.tx        = burst_mux(q.burst_idx);
        d.burst_idx = q.burst_idx + 3'h1;
        d.mclr      = (q.burst_idx == scr_pkg::BURST_CLR_IDX);
      end
    end
    // A frame in the clearing cycle still leaves its tick
    if (FRAME_TICK)
      d.frame_tick_bits = scr_pkg::OBS_TICK_ALL;
    // Key write wins over everything and restores defaults
    if (wr_done && (q.addr == scr_pkg::ADDR_KEY) &&
        (link.rx_byte == scr_pkg::RESET_KEY))
    begin
      d.cpi      = scr_pkg::CPI_RST;
      d.rest     = scr_pkg::REST_RST;
      d.frame_tick_bits      = scr_pkg::OBS_CLEAR;
      d.burst    = 1'b0;
      d.tx       = scr_pkg::READ_ZERO;
      d.chip_rst = 1'b1;
    end
  end

  // Register the whole state
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      q       <= '0;
      q.phase <= scr_pkg::PH_HEADER;
      q.cpi   <= scr_pkg::CPI_RST;
      q.rest  <= scr_pkg::REST_RST;
    end
    else
      q <= d;
  end

  // Outputs straight from state flops
  assign link.tx_byte = q.tx;
  assign REST_FORCE   = q.rest;
  assign CPI_SELECT   = q.cpi;
  assign CHIP_RESET   = q.chip_rst;
  assign MOTION_CLEAR = q.mclr;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  logic key_wr; // Key written to the reset register
  assign key_wr = wr_done && (q.addr == scr_pkg::ADDR_KEY) &&
                  (link.rx_byte == scr_pkg::RESET_KEY);

  cfg_write_a: assert property (
    (wr_done && (q.addr == scr_pkg::ADDR_CFG)) |=>
      (REST_FORCE == $past(link.rx_byte[5:4])) && (CPI_SELECT == $past(link.rx_byte[7])))
    else $error("configuration write not stored");
  cfg_read_a: assert property (
    (hdr_done && (link.rx_byte == {1'b0, scr_pkg::ADDR_CFG})) |=>
      (link.tx_byte == {$past(q.cpi), 1'b0, $past(q.rest), 4'h0}))
    else $error("configuration read wrong");
  mode_read_a: assert property (
    (hdr_done && (link.rx_byte == {1'b0, scr_pkg::ADDR_OBS})) |=>
      (link.tx_byte[7:6] == $past(POWER_MODE)) && (link.tx_byte[5:4] == 2'h0))
    else $error("power mode not reported");
  tick_set_a: assert property (
    FRAME_TICK |=> (q.frame_tick_bits == scr_pkg::OBS_TICK_ALL) || CHIP_RESET)
    else $error("frame did not set tick bits");
  tick_clear_a: assert property (
    (wr_done && (q.addr == scr_pkg::ADDR_OBS) && !FRAME_TICK) |=> (q.frame_tick_bits == 4'h0))
    else $error("observation write did not clear");
  key_reset_a: assert property (
    key_wr |=> CHIP_RESET && (REST_FORCE == 2'h0) && !CPI_SELECT ##1 !CHIP_RESET)
    else $error("keyed reset misbehaved");
  inv_rev_a: assert property (
    (hdr_done && (link.rx_byte == {1'b0, scr_pkg::ADDR_NREV})) |=> (link.tx_byte == ~REVISION_ID))
    else $error("inverted revision wrong");
  inv_prod_a: assert property (
    (hdr_done && (link.rx_byte == {1'b0, scr_pkg::ADDR_NPROD})) |=> (link.tx_byte == ~PRODUCT_ID))
    else $error("inverted product wrong");
  burst_start_a: assert property (
    (hdr_done && (link.rx_byte == {1'b0, scr_pkg::ADDR_BURST})) |=>
      q.burst && (link.tx_byte == $past(MOTION_STAT)))
    else $error("burst did not start with motion status");
  motion_clr_a: assert property (
    (rd_done && q.burst && (q.burst_idx == 3'h3)) |=> MOTION_CLEAR ##1 !MOTION_CLEAR)
    else $error("motion not cleared after third byte");
  reserved_a: assert property (
    (hdr_done && (link.rx_byte == 8'h20)) |=> (link.tx_byte == 8'h00))
    else $error("reserved address not zero");
  // A byte that lands while select drops is ignored unless it is the reset key, so the checks
  // below only look at bytes taken inside an open frame
  burst_step_a: assert property (
    (link.active && rd_done && q.burst && (q.burst_idx == scr_pkg::BURST_FIRST)) |=>
      (link.tx_byte == $past(DELTA_Y)))
    else $error("burst second item wrong");
  burst_end_a: assert property (
    (link.active && rd_done && q.burst && (q.burst_idx == scr_pkg::BURST_LAST)) |=>
      (link.tx_byte == scr_pkg::READ_ZERO))
    else $error("burst past end not zero");
  single_zero_a: assert property (
    (link.active && rd_done && !q.burst) |=> (link.tx_byte == scr_pkg::READ_ZERO))
    else $error("single read repeat not zero");
  // Writes elsewhere, other than the reset key, must never disturb the configuration flops
  cfg_hold_a: assert property (
    (wr_done && (q.addr != scr_pkg::ADDR_CFG) && !key_wr) |=>
      $stable(REST_FORCE) && $stable(CPI_SELECT))
    else $error("configuration changed by another write");

  // Main scenarios; the bench reaches all but tick_c, as no frame comes during a write
  burst_c:   cover property (rd_done && q.burst && (q.burst_idx == 3'h6));
  tick_c:    cover property (wr_done && (q.addr == scr_pkg::ADDR_OBS) && FRAME_TICK);
  key_c:     cover property (key_wr);
  cfg_c:     cover property (wr_done && (q.addr == scr_pkg::ADDR_CFG));
  clear_c:   cover property (MOTION_CLEAR);

endmodule // scr_regs

// *** core/scr_shifter.sv ***
// Serial shifter: samples the four-wire port on the reference clock.
// Assumes clock idles high, data changes on falling and is taken on rising edges.
`timescale 1ns/1ps
module scr_shifter (
  input  wire logic clk,        // Reference clock
  input  wire logic rst,        // Synchronous reset, active high
  input  wire logic sclk_in,    // Serial clock pin
  input  wire logic mosi_in,    // Serial data in pin
  input  wire logic sel_n_in,   // Select pin, active low
  output logic      miso_o,     // Serial data out value
  output logic      miso_oe,    // Serial data out enable
  scr_byte_if.port  bus         // Byte handshake
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] sclk_s;   // Clock sync pair plus previous sample
    logic [1:0] mosi_s;   // Data sync pair
    logic [1:0] sel_s;    // Select sync pair, reset to idle
    logic [2:0] bit_cnt;  // Bits taken in the current byte
    logic [7:0] rx_sh;    // Incoming shift register
    logic [7:0] tx_sh;    // Outgoing shift register
    logic [7:0] rx_byte;  // Last full byte
    logic       done;     // Byte pulse
    logic       miso;     // Data out
    logic       oe;       // Data out enable
  } scr_shift_type;

  scr_shift_type q, d;
  logic          active;  // Select seen low after sync
  logic          rise;    // Serial clock rising edge
  logic          fall;    // Serial clock falling edge

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Edges come only from synchronised samples, never the first stage
  always_comb
  begin
    d         = q;
    d.sclk_s  = {q.sclk_s[1:0], sclk_in};
    d.mosi_s  = {q.mosi_s[0], mosi_in};
    d.sel_s   = {q.sel_s[0], sel_n_in};
    d.done    = 1'b0;
    active    = !q.sel_s[1];
    rise      = q.sclk_s[1] && !q.sclk_s[2];
    fall      = !q.sclk_s[1] && q.sclk_s[2];
    if (!active)
    begin
      // Frame over: release the line and restart the bit count
      d.bit_cnt = '0;
      d.oe      = 1'b0;
    end
    else
    begin
      d.oe = 1'b1;
      if (fall)
      begin
        // First falling edge of a byte loads what the bank offers
        if (q.bit_cnt == '0)
        begin
          d.miso  = bus.tx_byte[7];
          d.tx_sh = {bus.tx_byte[6:0], 1'b0};
        end
        else
        begin
          d.miso  = q.tx_sh[7];
          d.tx_sh = {q.tx_sh[6:0], 1'b0};
        end
      end
      if (rise)
      begin
        d.rx_sh   = {q.rx_sh[6:0], q.mosi_s[1]};
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == scr_pkg::BIT_LAST)
        begin
          d.done    = 1'b1;
          d.rx_byte = {q.rx_sh[6:0], q.mosi_s[1]};
        end
      end
    end
  end

  // Register the whole state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q       <= '0;
      q.sel_s <= 2'h3;
      q.sclk_s <= 3'h7;
    end
    else
      q <= d;
  end

  assign bus.active    = active;
  assign bus.byte_done = q.done;
  assign bus.rx_byte   = q.rx_byte;
  assign miso_o        = q.miso;
  assign miso_oe       = q.oe;

endmodule // scr_shifter

// *** tb/scr_host_model.sv ***
// Host model: serial port master framing header and data bytes.
// Assumes the device samples its pins on its own reference clock.
`timescale 1ns/1ps
module scr_host_model (
  input  wire logic clk,     // Reference clock, edge alignment and released-wire pattern
  output logic      sclk,    // Serial clock, idles high
  output logic      mosi,    // Serial data to device
  output logic      ncs_n,   // Select, active low
  input  wire logic miso,    // Device data value
  input  wire logic miso_oe  // Device drive enable
);
  // ****************************************************************
  // Wire level
  // ****************************************************************
  localparam int HALF = 24;        // Half of the 48 ns link period
  logic          last_q = 1'h0;    // Last wire level seen
  logic          miso_pin;         // Level on the shared data wire

  // Released wire holds no stale data: it shows a changing pattern
  assign miso_pin = miso_oe ? miso : ~last_q;
  always @(posedge clk) last_q <= miso_pin;

  initial
  begin
    sclk  = 1'h1;
    mosi  = 1'h0;
    ncs_n = 1'h1;
  end

  // ****************************************************************
  // Transfers
  // ****************************************************************
  // Data changes on the fall, is taken on the rise, MSB first
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'h0;
      mosi = tx[i];
      #HALF;
      sclk = 1'h1;
      rx[i] = miso_pin;
      #HALF;
    end
  endtask

  // Select settles before the first clock edge
  task automatic open_frame();
    @(negedge clk);
    ncs_n = 1'h0;
    #HALF;
  endtask

  // Gap long enough that the next select is seen as new
  task automatic close_frame();
    ncs_n = 1'h1;
    mosi  = ~mosi;
    #(4 * HALF);
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] dummy;
    open_frame();
    shift_byte({1'h1, addr}, dummy);
    shift_byte(data, dummy);
    close_frame();
  endtask

  // Caller picks the byte count; bursts are always read three deep or more
  task automatic read_reg(input logic [6:0] addr, input int n, output logic [7:0] q [8]);
    int cnt;
    cnt = n;
    if ((addr == scr_pkg::ADDR_BURST) && (cnt < 3))
      cnt = 3;
    open_frame();
    shift_byte({1'h0, addr}, q[0]);
    for (int k = 0; k < cnt; k++)
      shift_byte(8'h00, q[k]);
    close_frame();
  endtask
endmodule // scr_host_model

// *** tb/test_scr_regs.sv ***
// Self-checking bench for the configuration and status register bank.
// Assumes the host model drives the serial pins; sensor inputs change on falling edges.
`timescale 1ns/1ps
module test_scr_regs;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [7:0] REV_ID  = 8'h3c; // Arbitrary value
  localparam logic [7:0] PROD_ID = 8'h5d; // Arbitrary value
  logic       ref_clk = 1'h0;  // Reference clock
  logic       rst     = 1'h1;  // Synchronous reset
  logic       sclk, mosi, ncs_n, miso_o, miso_oe;
  logic       frame_tick = 1'h0;  // Frame pulse
  logic [1:0] power_mode = 2'h0;  // Mode level
  logic [7:0] item [7] = '{8'h81, 8'h12, 8'hf3, 8'h44, 8'h05, 8'h96, 8'h27};
  logic [1:0] rest_force;      // Forced rest output
  logic       cpi_select, chip_reset, motion_clear;
  logic [7:0] rd [8];          // Bytes read back
  int         errors = 0;
  int         comparisons = 0;
  int         n_reset = 0;     // Chip reset pulses seen
  int         n_clear = 0;     // Motion clear pulses seen

  always #2 ref_clk = ~ref_clk;

  // Count the one-cycle pulses where they are settled
  always @(negedge ref_clk)
  begin
    if (chip_reset === 1'h1) n_reset++;
    if (motion_clear === 1'h1) n_clear++;
  end

  scr_regs #(.REVISION_ID(REV_ID), .PRODUCT_ID(PROD_ID)) u_dut (
    .REF_CLK(ref_clk), .RST(rst), .SCLK(sclk), .MOSI(mosi), .NCS_N(ncs_n),
    .MISO_O(miso_o), .MISO_OE(miso_oe), .FRAME_TICK(frame_tick),
    .POWER_MODE(power_mode), .MOTION_STAT(item[0]), .DELTA_Y(item[1]),
    .DELTA_X(item[2]), .SURF_QUAL(item[3]), .SHUTTER_HI(item[4]),
    .SHUTTER_LO(item[5]), .MAX_PIXEL(item[6]), .REST_FORCE(rest_force),
    .CPI_SELECT(cpi_select), .CHIP_RESET(chip_reset), .MOTION_CLEAR(motion_clear)
  );

  scr_host_model u_host (
    .clk(ref_clk), .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n),
    .miso(miso_o), .miso_oe(miso_oe)
  );

  // ****************************************************************
  // Compare and close
  // ****************************************************************
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_count(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    cmp_byte("rest_force", 8'h00, {6'h0, rest_force});
    cmp_byte("cpi_select", 8'h00, {7'h0, cpi_select});
    u_host.read_reg(scr_pkg::ADDR_CFG, 1, rd);
    cmp_byte("cfg_reset", 8'h00, rd[0]);
    cmp_byte("miso_oe_idle", 8'h00, {7'h0, miso_oe});
  endtask

  // Every rest and resolution setting; reserved bits written high read back zero
  task automatic t_config();
    for (int c = 0; c < 8; c++)
    begin
      u_host.write_reg(scr_pkg::ADDR_CFG, {c[2], 1'h1, c[1:0], 4'hf});
      cmp_byte("rest_force", {6'h0, c[1:0]}, {6'h0, rest_force});
      cmp_byte("cpi_select", {7'h0, c[2]}, {7'h0, cpi_select});
      u_host.read_reg(scr_pkg::ADDR_CFG, 1, rd);
      cmp_byte("cfg_read", {c[2], 1'h0, c[1:0], 4'h0}, rd[0]);
    end
  endtask

  task automatic t_observe();
    for (int m = 0; m < 4; m++)
    begin
      @(negedge ref_clk);
      power_mode = m[1:0];
      frame_tick = 1'h1;
      @(negedge ref_clk);
      frame_tick = 1'h0;
      u_host.read_reg(scr_pkg::ADDR_OBS, 1, rd);
      cmp_byte("obs_tick", {m[1:0], 6'h0f}, rd[0]);
      u_host.write_reg(scr_pkg::ADDR_OBS, 8'h55 * m[7:0]);
      u_host.read_reg(scr_pkg::ADDR_OBS, 1, rd);
      cmp_byte("obs_clear", {m[1:0], 6'h00}, rd[0]);
    end
  endtask

  task automatic t_ident();
    u_host.read_reg(scr_pkg::ADDR_NREV, 1, rd);
    cmp_byte("inv_rev", ~REV_ID, rd[0]);
    u_host.read_reg(scr_pkg::ADDR_NPROD, 1, rd);
    cmp_byte("inv_prod", ~PROD_ID, rd[0]);
  endtask

  // A wrong key must give no reset pulse and leave the rest setting alone
  task automatic t_key();
    u_host.write_reg(scr_pkg::ADDR_CFG, 8'h90);
    u_host.write_reg(scr_pkg::ADDR_KEY, 8'h5b);
    cmp_count("reset_bad_key", 0, n_reset);
    cmp_byte("rest_kept", 8'h01, {6'h0, rest_force});
    u_host.write_reg(scr_pkg::ADDR_KEY, 8'h5a);
    cmp_count("reset_pulses", 1, n_reset);
    cmp_byte("rest_default", 8'h00, {6'h0, rest_force});
    cmp_byte("cpi_default", 8'h00, {7'h0, cpi_select});
    u_host.read_reg(scr_pkg::ADDR_KEY, 1, rd);
    cmp_byte("key_read", 8'h00, rd[0]);
  endtask

  // Shortest legal burst first: motion clears once after three bytes
  task automatic t_burst();
    u_host.read_reg(scr_pkg::ADDR_BURST, 3, rd);
    for (int k = 0; k < 3; k++)
      cmp_byte("burst_short", item[k], rd[k]);
    cmp_count("clear_short", 1, n_clear);
    u_host.read_reg(scr_pkg::ADDR_BURST, 8, rd);
    for (int k = 0; k < 7; k++)
      cmp_byte("burst_item", item[k], rd[k]);
    cmp_byte("burst_past_end", 8'h00, rd[7]);
    cmp_count("clear_pulses", 2, n_clear);
  endtask

  // Reset in mid-run brings the configuration back to its defaults
  task automatic t_rst_mid();
    u_host.write_reg(scr_pkg::ADDR_CFG, 8'hb0);
    cmp_byte("rest_before_rst", 8'h03, {6'h0, rest_force});
    @(negedge ref_clk);
    rst = 1'h1;
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    repeat (4) @(negedge ref_clk);
    cmp_byte("rest_after_rst", 8'h00, {6'h0, rest_force});
    cmp_byte("cpi_after_rst", 8'h00, {7'h0, cpi_select});
  endtask

  task automatic t_reserved();
    u_host.write_reg(7'h20, 8'hff);
    u_host.read_reg(7'h20, 1, rd);
    cmp_byte("reserved_read", 8'h00, rd[0]);
    u_host.read_reg(7'h41, 1, rd);
    cmp_byte("high_read", 8'h00, rd[0]);
    u_host.read_reg(scr_pkg::ADDR_CFG, 1, rd);
    cmp_byte("cfg_untouched", 8'h00, rd[0]);
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_config();
    t_observe();
    t_ident();
    t_key();
    t_burst();
    t_rst_mid();
    t_reserved();
    close_out();
  end

  // Run needs about 41 us; allow about seven times that
  initial
  begin
    #300000;
    errors++;
    close_out();
  end
endmodule // test_scr_regs
